// ==== core/eal_defines.svh ====
// Constants of the serial EEPROM configuration autoloader
`ifndef EAL_DEFINES_SVH
`define EAL_DEFINES_SVH
`define EAL_SIGNATURE 16'h1516
`define EAL_DEV_WRITE 8'hA0
`define EAL_DEV_READ 8'hA1
`define EAL_REGION_G1 4'h0
`define EAL_REGION_G2 4'h1
`define EAL_REGION_G3 4'h3
`define EAL_WORD_SIG 7'h00
`define EAL_WORD_REGION 7'h01
`define EAL_WORD_ID_LO 7'h02
`define EAL_WORD_ID_HI 7'h03
`define EAL_WORD_CLASS_LO 7'h04
`define EAL_WORD_CLASS_HI 7'h05
`define EAL_WORD_HDR 7'h06
`define EAL_WORD_SELFTEST 7'h08
`define EAL_LAST_G1 7'h01
`define EAL_LAST_G2 7'h09
`define EAL_LAST_G3 7'h11
`define EAL_OFF_ID 8'h00
`define EAL_OFF_CLASS 8'h04
`define EAL_OFF_HDR 8'h08
`define EAL_OFF_STAT 8'h0C
`define EAL_OFF_CTRL 8'h10
`define EAL_CTRL_RELOAD 0
`define EAL_BIT_ACK 4'h8
`define EAL_BYTE_ADDR 3'h1
`define EAL_BYTE_DEVRD 3'h2
`define EAL_BYTE_RD_LO 3'h3
`define EAL_BYTE_RD_HI 3'h4
`define EAL_REF_CLK_HZ 40000000
`define EAL_SCL_HZ 100000
`define EAL_QTR_CYC ((`EAL_REF_CLK_HZ + 4 * `EAL_SCL_HZ - 1) / (4 * `EAL_SCL_HZ))
`define EAL_ID_RESET 32'h0000_0000
`define EAL_CLASS_RESET 24'h00_0000
`define EAL_HDR_RESET 8'h00
`endif

// ==== core/eal_pkg.sv ====
// Types of the serial EEPROM configuration autoloader
package eal_pkg;
   typedef enum logic [1:0] {
      LD_IDLE  = 2'b00,
      LD_ISSUE = 2'b01,
      LD_WAIT  = 2'b11,
      LD_END   = 2'b10
   } eal_ld_st_t;

   typedef enum logic [1:0] {
      RD_IDLE  = 2'b00,
      RD_START = 2'b01,
      RD_BIT   = 2'b11,
      RD_STOP  = 2'b10
   } eal_rd_st_t;

   typedef struct packed {
      eal_rd_st_t st;
      logic [15:0] cnt;
      logic [1:0] q;
      logic [3:0] bitn;
      logic [2:0] byte_i;
      logic [7:0] shift;
      logic [7:0] addr;
      logic [15:0] data;
      logic done;
      logic err;
      logic scl;
      logic oe;
   } eal_rd_state_t;

   typedef struct packed {
      eal_ld_st_t st;
      logic ready_d;
      logic req;
      logic [6:0] word;
      logic [6:0] last;
      logic [3:0] region;
      logic [31:0] id;
      logic [23:0] class_code;
      logic [7:0] hdr;
      logic [7:0] self_test;
      logic busy;
      logic done;
      logic abort;
      logic [31:0] hrdata;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic hreadyout;
      logic hresp;
   } eal_ld_state_t;
endpackage

// ==== core/eal_word_if.sv ====
// Word request channel between the loader and the serial word reader
`timescale 1ns/1ps
interface eal_word_if;
   logic req;
   logic [6:0] word;
   logic done;
   logic err;
   logic [15:0] data;
   modport loader (output req, output word, input done, input err, input data);
   modport reader (input req, input word, output done, output err, output data);
endinterface

// ==== core/eal_word_reader.sv ====
// Two-wire random read of one 16-bit EEPROM word
`timescale 1ns/1ps
`include "eal_defines.svh"
module eal_word_reader #(
   parameter int QTR_CYC = `EAL_QTR_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Word channel
   eal_word_if.reader w,
   // EEPROM pins
   output logic eeprom_serial_clock_out,
   input wire logic eeprom_serial_data_in,
   output logic eeprom_serial_data_out,
   output logic eeprom_serial_data_oe
);
   import eal_pkg::*;

   eal_rd_state_t s;
   eal_rd_state_t next_s;
   logic tick;
   logic reading;
   logic [3:0] idx;

   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      tick = (s.cnt == 16'(QTR_CYC - 1));
      reading = (s.byte_i >= `EAL_BYTE_RD_LO);
      idx = {(s.byte_i == `EAL_BYTE_RD_HI), s.bitn[2:0]};
      next_s.cnt = (s.st == RD_IDLE || tick) ? 16'h0000 : s.cnt + 16'h0001;
      if (tick) begin
         next_s.q = s.q + 2'h1;
      end
      unique case (s.st)
         RD_IDLE: begin
            next_s.scl = 1'b1;
            next_s.oe = 1'b0;
            next_s.q = 2'h0;
            if (w.req) begin
               next_s.st = RD_START;
               next_s.byte_i = 3'h0;
               next_s.shift = `EAL_DEV_WRITE;
               next_s.addr = {w.word, 1'b0};
               next_s.err = 1'b0;
            end
         end
         RD_START: begin
            if (tick) begin
               unique case (s.q)
                  2'h0: begin
                     next_s.scl = 1'b0;
                     next_s.oe = 1'b0;
                  end
                  2'h1: next_s.scl = 1'b1;
                  2'h2: next_s.oe = 1'b1;
                  2'h3: begin
                     next_s.scl = 1'b0;
                     next_s.st = RD_BIT;
                     next_s.bitn = 4'h0;
                  end
               endcase
            end
         end
         RD_BIT: begin
            if (tick) begin
               unique case (s.q)
                  2'h0: begin
                     next_s.scl = 1'b0;
                     if (s.bitn == `EAL_BIT_ACK) begin
                        // Acknowledge the low byte only; the high byte ends the read
                        next_s.oe = (s.byte_i == `EAL_BYTE_RD_LO);
                     end else begin
                        next_s.oe = !reading && !s.shift[7];
                     end
                  end
                  2'h1: next_s.scl = 1'b1;
                  2'h2: begin
                     if (s.bitn == `EAL_BIT_ACK) begin
                        if (!reading && eeprom_serial_data_in) begin
                           next_s.err = 1'b1;
                        end
                     end else if (reading) begin
                        next_s.data[idx] = eeprom_serial_data_in;
                     end
                  end
                  2'h3: begin
                     next_s.scl = 1'b0;
                     next_s.shift = {s.shift[6:0], 1'b0};
                     next_s.bitn = s.bitn + 4'h1;
                     if (s.bitn == `EAL_BIT_ACK) begin
                        next_s.bitn = 4'h0;
                        if (s.err || s.byte_i == `EAL_BYTE_RD_HI) begin
                           next_s.st = RD_STOP;
                        end else if (s.byte_i == `EAL_BYTE_ADDR) begin
                           next_s.st = RD_START;
                           next_s.byte_i = `EAL_BYTE_DEVRD;
                           next_s.shift = `EAL_DEV_READ;
                        end else begin
                           next_s.byte_i = s.byte_i + 3'h1;
                           next_s.shift = s.addr;
                        end
                     end
                  end
               endcase
            end
         end
         RD_STOP: begin
            if (tick) begin
               unique case (s.q)
                  2'h0: begin
                     next_s.scl = 1'b0;
                     next_s.oe = 1'b1;
                  end
                  2'h1: next_s.scl = 1'b1;
                  2'h2: next_s.oe = 1'b0;
                  2'h3: begin
                     next_s.st = RD_IDLE;
                     next_s.done = 1'b1;
                  end
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         s <= '0;
         s.scl <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign w.done = s.done;
   assign w.err = s.err;
   assign w.data = s.data;
   assign eeprom_serial_clock_out = s.scl;
   // Open drain: only ever pulls low
   assign eeprom_serial_data_out = 1'b0;
   assign eeprom_serial_data_oe = s.oe;
endmodule

// ==== core/eal_autoload.sv ====
// Serial EEPROM configuration autoloader with AHB-Lite register slave
`timescale 1ns/1ps
`include "eal_defines.svh"
module eal_autoload #(
   parameter int QTR_CYC = `EAL_QTR_CYC,
   parameter logic [31:0] ID_RESET = `EAL_ID_RESET, // Arbitrary neutral value
   parameter logic [23:0] CLASS_RESET = `EAL_CLASS_RESET,
   parameter logic [7:0] HDR_RESET = `EAL_HDR_RESET
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Start conditions
   input wire logic power_good_input,
   input wire logic primary_reset_input_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // EEPROM pins
   output logic eeprom_serial_clock_out,
   input wire logic eeprom_serial_data_in,
   output logic eeprom_serial_data_out,
   output logic eeprom_serial_data_oe,
   // Loaded configuration
   output logic [31:0] identification_register,
   output logic [23:0] class_code_register,
   output logic [7:0] header_type_register,
   output logic [7:0] self_test_register,
   output logic autoload_busy
);
   import eal_pkg::*;

   eal_ld_state_t s;
   eal_ld_state_t next_s;
   logic ready;
   logic reload;
   logic addr_phase;
   logic [6:0] region_last;

   eal_word_if w ();

   eal_word_reader #(.QTR_CYC(QTR_CYC)) u_reader (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .w(w),
      .eeprom_serial_clock_out(eeprom_serial_clock_out),
      .eeprom_serial_data_in(eeprom_serial_data_in),
      .eeprom_serial_data_out(eeprom_serial_data_out),
      .eeprom_serial_data_oe(eeprom_serial_data_oe)
   );

   function automatic logic [31:0] read_mux(input eal_ld_state_t st, input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         `EAL_OFF_ID: r = st.id;
         `EAL_OFF_CLASS: r = {8'h00, st.class_code};
         `EAL_OFF_HDR: r = {16'h0000, st.self_test, st.hdr};
         `EAL_OFF_STAT: r = {24'h00_0000, st.region, 1'b0, st.abort, st.done, st.busy};
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   always_comb begin
      next_s = s;
      next_s.req = 1'b0;
      ready = power_good_input && primary_reset_input_n;
      next_s.ready_d = ready;
      // Zero-wait slave: every transfer completes OKAY in its first data cycle
      addr_phase = hsel && htrans[1] && hready;
      next_s.wr_pend = addr_phase && hwrite;
      next_s.wr_addr = haddr[7:0];
      if (addr_phase && !hwrite) begin
         next_s.hrdata = read_mux(s, haddr[7:0]);
      end
      reload = s.wr_pend && (s.wr_addr == `EAL_OFF_CTRL) && hwdata[`EAL_CTRL_RELOAD];
      // Undefined region codes are treated as group 1 only
      unique case (w.data[4:1])
         `EAL_REGION_G2: region_last = `EAL_LAST_G2;
         `EAL_REGION_G3: region_last = `EAL_LAST_G3;
         default: region_last = `EAL_LAST_G1;
      endcase
      unique case (s.st)
         LD_IDLE: begin
            // A reload requested while loading is dropped, the load already in flight wins
            if ((ready && !s.ready_d) || reload) begin
               next_s.st = LD_ISSUE;
               next_s.word = `EAL_WORD_SIG;
               next_s.last = `EAL_LAST_G1;
               next_s.busy = 1'b1;
               next_s.done = 1'b0;
               next_s.abort = 1'b0;
            end
         end
         LD_ISSUE: begin
            next_s.req = 1'b1;
            next_s.st = LD_WAIT;
         end
         LD_WAIT: begin
            if (w.done) begin
               next_s.st = LD_ISSUE;
               next_s.word = s.word + 7'h01;
               unique case (s.word)
                  `EAL_WORD_REGION: begin
                     next_s.region = w.data[4:1];
                     next_s.last = region_last;
                  end
                  `EAL_WORD_ID_LO: next_s.id[15:0] = w.data;
                  `EAL_WORD_ID_HI: next_s.id[31:16] = w.data;
                  `EAL_WORD_CLASS_LO: next_s.class_code[7:0] = w.data[15:8];
                  `EAL_WORD_CLASS_HI: next_s.class_code[23:8] = w.data;
                  `EAL_WORD_HDR: next_s.hdr = w.data[7:0];
                  `EAL_WORD_SELFTEST: next_s.self_test = w.data[15:8];
                  default: next_s.st = LD_ISSUE;
               endcase
               if (w.err || (s.word == `EAL_WORD_SIG && w.data != `EAL_SIGNATURE)) begin
                  // Only the load fields roll back, so a bus read in this cycle still lands
                  next_s.word = s.word;
                  next_s.region = s.region;
                  next_s.last = s.last;
                  next_s.id = s.id;
                  next_s.class_code = s.class_code;
                  next_s.hdr = s.hdr;
                  next_s.self_test = s.self_test;
                  next_s.abort = 1'b1;
                  next_s.st = LD_END;
               end else if (s.word == next_s.last) begin
                  next_s.st = LD_END;
               end
            end
         end
         LD_END: begin
            next_s.busy = 1'b0;
            next_s.done = !s.abort;
            next_s.st = LD_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         s <= '0;
         s.id <= ID_RESET;
         s.class_code <= CLASS_RESET;
         s.hdr <= HDR_RESET;
         s.hreadyout <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign w.req = s.req;
   assign w.word = s.word;
   assign hrdata = s.hrdata;
   assign hreadyout = s.hreadyout;
   assign hresp = s.hresp;
   assign identification_register = s.id;
   assign class_code_register = s.class_code;
   assign header_type_register = s.hdr;
   assign self_test_register = s.self_test;
   assign autoload_busy = s.busy;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   a_start_trigger: assert property (s.st == LD_IDLE && ready && !s.ready_d |=> s.st == LD_ISSUE ##1 w.req)
      else $error("autoload did not start on start condition rise");
   a_single_word: assert property (w.req |=> !w.req [*2])
      else $error("word request longer than one cycle");
   a_bad_signature: assert property (s.st == LD_WAIT && w.done && s.word == `EAL_WORD_SIG
      && w.data != `EAL_SIGNATURE |=> s.abort && s.st == LD_END ##1 s.id == $past(s.id, 2) && !s.done)
      else $error("bad signature did not abort");
   a_ascend_words: assert property (s.st == LD_WAIT && w.done && !w.err && s.word != s.last
      && s.word != `EAL_WORD_SIG |=> s.word == $past(s.word) + 7'h01)
      else $error("words not read in ascending order");
   a_region_g1: assert property (s.st == LD_WAIT && w.done && !w.err && s.word == `EAL_WORD_REGION
      && w.data[4:1] == `EAL_REGION_G1 |=> s.st == LD_END ##1 s.done)
      else $error("group 1 load did not stop after region word");
   a_region_g2: assert property (s.st == LD_WAIT && w.done && !w.err && s.word == `EAL_WORD_REGION
      && w.data[4:1] == `EAL_REGION_G2 |=> s.last == `EAL_LAST_G2)
      else $error("group 2 end word wrong");
   a_region_g3: assert property (s.st == LD_WAIT && w.done && !w.err && s.word == `EAL_WORD_REGION
      && w.data[4:1] == `EAL_REGION_G3 |=> s.last == `EAL_LAST_G3)
      else $error("group 3 end word wrong");
   a_class_low: assert property (s.st == LD_WAIT && w.done && !w.err && s.word == `EAL_WORD_CLASS_LO
      |=> class_code_register[7:0] == $past(w.data[15:8]))
      else $error("class code low byte not loaded from odd byte");
   a_id_load: assert property (s.st == LD_WAIT && w.done && !w.err && s.word == `EAL_WORD_ID_LO
      |=> identification_register[15:0] == $past(w.data))
      else $error("identification low half not loaded");
   a_self_test: assert property (s.st == LD_WAIT && w.done && !w.err && s.word == `EAL_WORD_SELFTEST
      |=> self_test_register == $past(w.data[15:8]))
      else $error("self-test byte not loaded");
endmodule

// ==== bench/eal_eeprom_model.sv ====
// Behavioural two-wire serial EEPROM, 256 by 8, answering only device address zero
`timescale 1ns/1ps
module eal_eeprom_model (
   // Link pins
   input wire logic scl,
   input wire logic sda,
   output logic pull,
   // Fault control
   input wire logic nack_dev
);
   logic [7:0] mem [0:255];
   logic [7:0] sh = 8'h00;
   logic [7:0] ptr = 8'h00;
   logic [7:0] last_ptr = 8'h00;
   logic [7:0] exp_addr = 8'h00;
   logic rd = 1'b0;
   logic mack = 1'b0;
   int mode = 0;
   int bitc = 0;
   int words = 0;
   int ntx = 0;
   int max_tx = 0;
   int seq_err = 0;
   initial pull = 1'b0;

   // One data bit per low phase of the clock; the last byte ends without master ack
   task automatic drive_bit();
      if (bitc < 8) begin
         if (bitc == 0) begin
            last_ptr = ptr;
            ntx++;
            if (ntx > max_tx) max_tx = ntx;
         end
         pull = ~mem[ptr][bitc]; // Data leaves LSB first, opposite to the address
         bitc++;
      end else if (bitc == 8) begin
         pull = 1'b0;
         bitc = 9;
      end else begin
         pull = 1'b0;
         mode = 0;
      end
   endtask

   // Start condition
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         mode = 1;
         bitc = 0;
      end
   end
   // Stop condition; released wire goes to its pull-up
   always @(posedge sda) begin
      if (scl === 1'b1) mode = 0;
   end
   always @(posedge scl) begin
      if ((mode == 1 || mode == 2) && bitc < 8) begin
         sh = {sh[6:0], sda}; // Select and address bytes arrive MSB first
         bitc++;
      end else if (mode == 3 && bitc == 9) begin
         mack = ~sda;
      end
   end
   always @(negedge scl) begin
      if ((mode == 1 || mode == 2) && bitc == 8) begin
         if (mode == 1) begin
            rd = sh[0];
            pull = (sh[7:1] === 7'h50) && !nack_dev; // Strapped to device address zero
         end else begin
            ptr = sh; // Byte address of a 7-bit word index, low byte first
            if (sh !== exp_addr) seq_err++;
            exp_addr = sh + 8'h02;
            pull = 1'b1;
         end
         bitc = 9;
         if (!pull) mode = 0;
      end else if ((mode == 1 || mode == 2) && bitc == 9) begin
         pull = 1'b0;
         bitc = 0;
         if (mode == 2) begin
            mode = 0;
         end else if (!rd) begin
            mode = 2;
         end else begin
            mode = 3;
            words++;
            ntx = 0;
            drive_bit();
         end
      end else if (mode == 3) begin
         if (bitc == 9) begin
            ptr = ptr + 8'h01;
            bitc = mack ? 0 : 10;
         end
         drive_bit();
      end
   end
endmodule

// ==== bench/eal_autoload_test.sv ====
// Self-checking bench for the serial EEPROM configuration autoloader
`timescale 1ns/1ps
module eal_autoload_test;
   import eal_pkg::*;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic power_good_input = 1'b0;
   logic primary_reset_input_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic nack_dev = 1'b0;
   logic hready, hreadyout, hresp, scl, sda_oe, sda_out, pull, busy;
   logic [31:0] hrdata, id, rd, new_id, exp_id;
   logic [23:0] cls;
   logic [7:0] hdr, bist;
   wire sda;
   int fail_count = 0;
   int n_compared = 0;
   logic [7:0] img [13] = '{8'h16, 8'h15, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hAA, 8'h55, 8'h66, 8'h77, 8'h88};
   logic [7:0] code [3] = '{8'hE3, 8'h01, 8'h06};
   logic [7:0] lastb [3] = '{8'h13, 8'h03, 8'h23};
   logic [7:0] rgn [3] = '{8'h10, 8'h00, 8'h30};
   int nwords [3] = '{10, 2, 18};

   always #12.5 ref_clk = ~ref_clk;
   // Single slave: its ready is the bus ready
   assign hready = (hreadyout === 1'b0) ? 1'b0 : 1'b1;
   // Open-drain data wire with pull-up
   assign sda = ((sda_oe === 1'b1 && sda_out === 1'b0) || pull === 1'b1) ? 1'b0 : 1'b1;

   eal_autoload #(.QTR_CYC(2)) DUT (.ref_clk(ref_clk), .rstn(rstn), .power_good_input(power_good_input),
      .primary_reset_input_n(primary_reset_input_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .eeprom_serial_clock_out(scl), .eeprom_serial_data_in(sda),
      .eeprom_serial_data_out(sda_out), .eeprom_serial_data_oe(sda_oe), .identification_register(id),
      .class_code_register(cls), .header_type_register(hdr), .self_test_register(bist),
      .autoload_busy(busy));
   eal_eeprom_model MEM (.scl(scl), .sda(sda), .pull(pull), .nack_dev(nack_dev));

   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Bounded wait for one edge at which the slave is ready
   task automatic ready_edge();
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         check("bus ready timeout", 32'h0, 32'h1);
         final_report();
      end
   endtask

   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      ready_edge();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      ready_edge();
      q = hrdata;
   endtask

   task automatic wait_busy(input logic lvl, input int limit);
      int n;
      n = 0;
      while (busy !== lvl) begin
         @(posedge ref_clk);
         n++;
         if (n > limit) begin
            check("busy wait", {31'h0, busy}, {31'h0, lvl});
            final_report();
         end
      end
   endtask

   task automatic reload();
      MEM.words = 0;
      MEM.max_tx = 0;
      MEM.exp_addr = 8'h00;
      ahb(1'b1, 32'h10, 32'h1, rd);
      wait_busy(1'b1, 20);
      wait_busy(1'b0, 30000);
      repeat (3) @(posedge ref_clk);
   endtask

   initial begin
      for (int i = 0; i < 256; i++) MEM.mem[i] = 8'hC3; // Reserved bytes hold junk
      for (int i = 0; i < 13; i++) MEM.mem[i] = img[i]; // Signature 1516h little endian
      MEM.mem[8'h11] = 8'h00; // Unsupported self-test kept zero
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      for (int a = 0; a < 20; a += 4) begin
         ahb(1'b0, a, 32'h0, rd);
         check("reset value", rd, 32'h0);
      end
      check("hresp", {31'h0, hresp}, 32'h0);
      exp_id = 32'h0;
      for (int i = 0; i < 3; i++) begin
         MEM.mem[2] = code[i]; // Only listed region codes, reserved bits set in all but the last
         new_id = 32'h4433_2211 + 32'h0101_0101 * i;
         for (int k = 0; k < 4; k++) MEM.mem[4 + k] = new_id[8 * k +: 8];
         if (i == 0) begin
            MEM.exp_addr = 8'h00;
            primary_reset_input_n <= 1'b1;
            repeat (10) @(posedge ref_clk);
            check("busy before later start", {31'h0, busy}, 32'h0);
            power_good_input <= 1'b1;
            wait_busy(1'b1, 10);
            wait_busy(1'b0, 30000);
            repeat (3) @(posedge ref_clk);
         end else begin
            reload();
         end
         if (nwords[i] > 2) exp_id = new_id;
         check("words read", MEM.words, nwords[i]);
         check("last byte", {24'h0, MEM.last_ptr}, {24'h0, lastb[i]});
         check("bytes per access", MEM.max_tx, 2);
         check("order errors", MEM.seq_err, 0);
         check("id port", id, exp_id);
         ahb(1'b0, 32'h00, 32'h0, rd);
         check("id reg", rd, exp_id);
         ahb(1'b0, 32'h0C, 32'h0, rd);
         check("status", rd, {24'h0, rgn[i] | 8'h02});
      end
      check("class port", {8'h0, cls}, 32'h0077_6655);
      check("header port", {24'h0, hdr}, 32'h88);
      check("self-test port", {24'h0, bist}, 32'h0);
      ahb(1'b0, 32'h04, 32'h0, rd);
      check("class reg", rd, 32'h0077_6655);
      ahb(1'b0, 32'h08, 32'h0, rd);
      check("header reg", rd, 32'h88);
      MEM.mem[1] = 8'h16;
      MEM.mem[4] = 8'h5A;
      reload();
      check("bad signature words", MEM.words, 1);
      check("bad signature id", id, exp_id);
      ahb(1'b0, 32'h0C, 32'h0, rd);
      check("bad signature abort", rd & 32'h4, 32'h4);
      MEM.mem[1] = 8'h15;
      nack_dev = 1'b1;
      reload();
      ahb(1'b0, 32'h0C, 32'h0, rd);
      check("no ack abort", rd & 32'h4, 32'h4);
      check("no ack id", id, exp_id);
      check("no ack words", MEM.words, 0);
      nack_dev = 1'b0;
      ahb(1'b1, 32'h00, 32'hFFFF_FFFF, rd);
      ahb(1'b0, 32'h00, 32'h0, rd);
      check("id read only", rd, exp_id);
      ahb(1'b0, 32'h20, 32'h0, rd);
      check("unmapped", rd, 32'h0);
      final_report();
   end
endmodule
